/* File: core/csf_cond_eval.sv */
/*
  condition code evaluator for conditional jumps.
  assumes flags arrive from the status register over csf_flag_if.
*/
`timescale 1ns/100ps
`default_nettype none
`include "csf_params.svh"
module csf_cond_eval
  import csf_pkg::*;
(
  csf_flag_if.eval fl
);
  // ==========
  // decode
  function automatic logic cond_true(input logic [3:0] code, input logic c, input logic z,
                                     input logic s, input logic v);
    case (code)
      `CSF_CC_NEVER: cond_true = 1'b0;
      `CSF_CC_ALWAYS: cond_true = 1'b1;
      `CSF_CC_C: cond_true = c;
      `CSF_CC_NC: cond_true = ~c;
      `CSF_CC_Z: cond_true = z;
      `CSF_CC_NONZERO: cond_true = ~z;
      `CSF_CC_POSITIVE: cond_true = ~s;
      `CSF_CC_NEGATIVE: cond_true = s;
      `CSF_CC_OV: cond_true = v;
      `CSF_CC_NO_OVERFLOW: cond_true = ~v;
      `CSF_CC_SIGNED_AT_LEAST: cond_true = ~(s ^ v);
      `CSF_CC_SIGNED_BELOW: cond_true = s ^ v;
      `CSF_CC_SIGNED_ABOVE: cond_true = ~(z | (s ^ v));
      `CSF_CC_SIGNED_AT_MOST: cond_true = z | (s ^ v);
      `CSF_CC_UNSIGNED_ABOVE: cond_true = ~c & ~z;
      `CSF_CC_UNSIGNED_AT_MOST: cond_true = c | z;
      default: cond_true = 1'b0;
    endcase
  endfunction : cond_true

  // only cond and c, z, s, v feed the decision
  assign fl.taken = cond_true(fl.cond, fl.carry, fl.zero, fl.sign, fl.ovf);
endmodule : csf_cond_eval
`default_nettype wire

/* File: core/csf_flag_if.sv */
/*
  interface carrying the flag bits from the flag register to the condition unit.
  assumes a single clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface csf_flag_if;
  logic carry;
  logic zero;
  logic sign;
  logic ovf;
  logic [3:0] cond;
  logic taken;
  modport src (output carry, output zero, output sign, output ovf, output cond, input taken);
  modport eval (input carry, input zero, input sign, input ovf, input cond, output taken);
endinterface : csf_flag_if
`default_nettype wire

/* File: core/csf_params.svh */
/*
  constants for the cpu status flag block: bit positions, register offset, codes.
  assumes inclusion by bare name from core/ files.
*/
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH
`define CSF_FLAGS_OFFSET 8'hd5
`define CSF_FLAGS_RESET 8'h00
`define CSF_BIT_C 7
`define CSF_BIT_Z 6
`define CSF_BIT_S 5
`define CSF_BIT_V 4
`define CSF_BIT_D 3
`define CSF_BIT_H 2
`define CSF_BIT_FAST_IRQ 1
`define CSF_BIT_BA 0
`define CSF_CC_NEVER 4'h0
`define CSF_CC_SIGNED_BELOW 4'h1
`define CSF_CC_SIGNED_AT_MOST 4'h2
`define CSF_CC_UNSIGNED_AT_MOST 4'h3
`define CSF_CC_OV 4'h4
`define CSF_CC_NEGATIVE 4'h5
`define CSF_CC_Z 4'h6
`define CSF_CC_C 4'h7
`define CSF_CC_ALWAYS 4'h8
`define CSF_CC_SIGNED_AT_LEAST 4'h9
`define CSF_CC_SIGNED_ABOVE 4'ha
`define CSF_CC_UNSIGNED_ABOVE 4'hb
`define CSF_CC_NO_OVERFLOW 4'hc
`define CSF_CC_POSITIVE 4'hd
`define CSF_CC_NONZERO 4'he
`define CSF_CC_NC 4'hf
`endif

/* File: core/csf_pkg.sv */
/*
  types for the cpu status flag block.
  assumes csf_params.svh is available.
*/
package csf_pkg;
  typedef enum logic [3:0] {
    CSF_OP_NONE = 4'h0,
    CSF_OP_ADD = 4'h1,
    CSF_OP_SUB = 4'h2,
    CSF_OP_LOGIC = 4'h3,
    CSF_OP_SHIFT = 4'h4,
    CSF_OP_BITTEST = 4'h5,
    CSF_OP_SET_C = 4'h6,
    CSF_OP_CLR_C = 4'h7,
    CSF_OP_INV_C = 4'h8,
    CSF_OP_BANK0 = 4'h9,
    CSF_OP_BANK1 = 4'ha,
    CSF_OP_FAST_IRQ = 4'hb,
    CSF_OP_INT_RETURN = 4'hc,
    CSF_OP_DEC_ADJ = 4'hd
  } csf_op_e;
  typedef enum logic [1:0] {
    CSF_ST_RUN = 2'b00,
    CSF_ST_FAST = 2'b01
  } csf_state_e;
endpackage : csf_pkg

/* File: core/csf_status_flags.sv */
/*
  status flag register with flag update, decimal adjust and jump condition check.
  assumes the sequencer issues one op per cycle and supplies operands and results.
*/
`timescale 1ns/100ps
`default_nettype none
`include "csf_params.svh"
module csf_status_flags
  import csf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] op,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic carry_in_use,
  input wire logic [7:0] result,
  input wire logic shift_out,
  input wire logic [3:0] jump_condition_field,
  output logic jump_taken,
  output logic [7:0] adj_result,
  output logic irq_block,
  output logic fast_return,
  output logic bank_sel,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  // ==========
  // state
  logic [7:0] cpu_status_flags;
  logic [7:0] next_flags;
  logic [8:0] sum9;
  logic [4:0] low5;
  logic cin;
  logic [7:0] adj_corr;
  logic adj_carry;
  csf_state_e irq_state;
  csf_op_e opk;
  csf_flag_if flg();

  assign opk = csf_op_e'(op);
  assign cin = carry_in_use & cpu_status_flags[`CSF_BIT_C];

  // ==========
  // arithmetic helpers
  always_comb begin
    if (opk == CSF_OP_SUB) begin
      sum9 = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
      low5 = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
    end else begin
      sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
      low5 = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    end
  end

  // ==========
  // decimal adjust
  always_comb begin
    adj_corr = 8'h00;
    adj_carry = cpu_status_flags[`CSF_BIT_C];
    if (!cpu_status_flags[`CSF_BIT_D]) begin
      if (cpu_status_flags[`CSF_BIT_H] || (opa[3:0] > 4'h9)) begin
        adj_corr[3:0] = 4'h6;
      end
      if (cpu_status_flags[`CSF_BIT_C] || (opa > 8'h99)) begin
        adj_corr[7:4] = 4'h6;
        adj_carry = 1'b1;
      end
      adj_result = opa + adj_corr;
    end else begin
      if (cpu_status_flags[`CSF_BIT_H]) begin
        adj_corr[3:0] = 4'h6;
      end
      if (cpu_status_flags[`CSF_BIT_C]) begin
        adj_corr[7:4] = 4'h6;
      end
      adj_result = opa - adj_corr;
    end
  end

  // ==========
  // next flag value
  always_comb begin
    next_flags = cpu_status_flags;
    case (opk)
      CSF_OP_ADD, CSF_OP_SUB: begin
        next_flags[`CSF_BIT_C] = sum9[8];
        next_flags[`CSF_BIT_Z] = (sum9[7:0] == 8'h00);
        next_flags[`CSF_BIT_S] = sum9[7];
        if (opk == CSF_OP_ADD) begin
          next_flags[`CSF_BIT_V] = (opa[7] == opb[7]) && (sum9[7] != opa[7]);
        end else begin
          next_flags[`CSF_BIT_V] = (opa[7] != opb[7]) && (sum9[7] != opa[7]);
        end
        next_flags[`CSF_BIT_D] = (opk == CSF_OP_SUB);
        next_flags[`CSF_BIT_H] = low5[4];
      end
      CSF_OP_LOGIC: begin
        next_flags[`CSF_BIT_Z] = (result == 8'h00);
        next_flags[`CSF_BIT_S] = result[7];
        next_flags[`CSF_BIT_V] = 1'b0;
      end
      CSF_OP_SHIFT: begin
        next_flags[`CSF_BIT_C] = shift_out;
        next_flags[`CSF_BIT_Z] = (result == 8'h00);
        next_flags[`CSF_BIT_S] = result[7];
        next_flags[`CSF_BIT_V] = result[7] ^ opa[7];
      end
      CSF_OP_BITTEST: begin
        next_flags[`CSF_BIT_Z] = (result == 8'h00);
      end
      CSF_OP_DEC_ADJ: begin
        next_flags[`CSF_BIT_C] = adj_carry;
        next_flags[`CSF_BIT_Z] = (adj_result == 8'h00);
        next_flags[`CSF_BIT_S] = adj_result[7];
      end
      CSF_OP_SET_C: next_flags[`CSF_BIT_C] = 1'b1;
      CSF_OP_CLR_C: next_flags[`CSF_BIT_C] = 1'b0;
      CSF_OP_INV_C: next_flags[`CSF_BIT_C] = ~cpu_status_flags[`CSF_BIT_C];
      CSF_OP_BANK0: next_flags[`CSF_BIT_BA] = 1'b0;
      CSF_OP_BANK1: next_flags[`CSF_BIT_BA] = 1'b1;
      CSF_OP_FAST_IRQ: next_flags[`CSF_BIT_FAST_IRQ] = 1'b1;
      CSF_OP_INT_RETURN: next_flags[`CSF_BIT_FAST_IRQ] = 1'b0;
      default: next_flags = cpu_status_flags;
    endcase
  end

  // ==========
  // status register; flag update wins over a same-cycle direct write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cpu_status_flags <= `CSF_FLAGS_RESET;
    end else if (opk != CSF_OP_NONE) begin
      cpu_status_flags <= next_flags;
    end else if (reg_wr && (reg_addr == `CSF_FLAGS_OFFSET)) begin
      cpu_status_flags <= reg_wdata;
    end
  end

  // ==========
  // fast interrupt tracking
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_state <= CSF_ST_RUN;
    end else begin
      case (irq_state)
        CSF_ST_RUN: if (opk == CSF_OP_FAST_IRQ) irq_state <= CSF_ST_FAST;
        CSF_ST_FAST: if (opk == CSF_OP_INT_RETURN) irq_state <= CSF_ST_RUN;
        default: irq_state <= CSF_ST_RUN;
      endcase
    end
  end

  assign irq_block = cpu_status_flags[`CSF_BIT_FAST_IRQ];
  assign fast_return = (opk == CSF_OP_INT_RETURN) && cpu_status_flags[`CSF_BIT_FAST_IRQ];
  assign bank_sel = cpu_status_flags[`CSF_BIT_BA];

  // ==========
  // register read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && (reg_addr == `CSF_FLAGS_OFFSET)) begin
      reg_rdata <= cpu_status_flags;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========
  // jump condition
  assign flg.carry = cpu_status_flags[`CSF_BIT_C];
  assign flg.zero = cpu_status_flags[`CSF_BIT_Z];
  assign flg.sign = cpu_status_flags[`CSF_BIT_S];
  assign flg.ovf = cpu_status_flags[`CSF_BIT_V];
  assign flg.cond = jump_condition_field;
  assign jump_taken = flg.taken;

  csf_cond_eval u_cond (
    .fl(flg)
  );

  // ==========
  // checks
  property p_carry_set;
    @(posedge clk_sys) disable iff (rst)
    opk == CSF_OP_SET_C |=> cpu_status_flags[`CSF_BIT_C] && cpu_status_flags[6:0] == $past(cpu_status_flags[6:0]);
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("set carry wrong");

  property p_logic_v;
    @(posedge clk_sys) disable iff (rst)
    opk == CSF_OP_LOGIC |=> !cpu_status_flags[`CSF_BIT_V] && cpu_status_flags[`CSF_BIT_Z] == ($past(result) == 8'h00);
  endproperty
  a_logic_v: assert property (p_logic_v) else $error("logic flags wrong");

  property p_shift_c;
    @(posedge clk_sys) disable iff (rst)
    opk == CSF_OP_SHIFT |=> cpu_status_flags[`CSF_BIT_C] == $past(shift_out) && cpu_status_flags[`CSF_BIT_S] == $past(result[7]);
  endproperty
  a_shift_c: assert property (p_shift_c) else $error("shift carry wrong");

  property p_add_c;
    @(posedge clk_sys) disable iff (rst)
    (opk == CSF_OP_ADD && !carry_in_use) |=> cpu_status_flags[`CSF_BIT_C] == (({1'b0, $past(opa)} + {1'b0, $past(opb)}) > 9'h0ff);
  endproperty
  a_add_c: assert property (p_add_c) else $error("add carry wrong");

  property p_sub_d;
    @(posedge clk_sys) disable iff (rst)
    opk == CSF_OP_SUB |=> cpu_status_flags[`CSF_BIT_D];
  endproperty
  a_sub_d: assert property (p_sub_d) else $error("decimal bit wrong");

  property p_bank;
    @(posedge clk_sys) disable iff (rst)
    opk == CSF_OP_BANK1 ##1 opk == CSF_OP_NONE && !reg_wr |=> bank_sel;
  endproperty
  a_bank: assert property (p_bank) else $error("bank bit wrong");

  property p_fast_irq;
    @(posedge clk_sys) disable iff (rst)
    opk == CSF_OP_FAST_IRQ |=> irq_block && irq_state == CSF_ST_FAST;
  endproperty
  a_fast_irq: assert property (p_fast_irq) else $error("fast irq bit wrong");

  property p_never;
    @(posedge clk_sys) disable iff (rst)
    jump_condition_field == `CSF_CC_NEVER |-> !jump_taken;
  endproperty
  a_never: assert property (p_never) else $error("never code taken");

  property p_signed_at_least;
    @(posedge clk_sys) disable iff (rst)
    jump_condition_field == `CSF_CC_SIGNED_AT_LEAST |-> jump_taken == !(flg.sign ^ flg.ovf);
  endproperty
  a_signed_at_least: assert property (p_signed_at_least) else $error("signed at least code wrong");

  property p_unsigned_above;
    @(posedge clk_sys) disable iff (rst)
    jump_condition_field == `CSF_CC_UNSIGNED_ABOVE |-> jump_taken == (!flg.carry && !flg.zero);
  endproperty
  a_unsigned_above: assert property (p_unsigned_above) else $error("unsigned above code wrong");

  property p_signed_below;
    @(posedge clk_sys) disable iff (rst)
    jump_condition_field == `CSF_CC_SIGNED_BELOW |-> jump_taken == (flg.sign ^ flg.ovf);
  endproperty
  a_signed_below: assert property (p_signed_below) else $error("signed below code wrong");

  property p_unsigned_at_most;
    @(posedge clk_sys) disable iff (rst)
    jump_condition_field == `CSF_CC_UNSIGNED_AT_MOST |-> jump_taken == (flg.carry || flg.zero);
  endproperty
  a_unsigned_at_most: assert property (p_unsigned_at_most) else $error("unsigned at most code wrong");

  property p_always;
    @(posedge clk_sys) disable iff (rst)
    jump_condition_field == `CSF_CC_ALWAYS |-> jump_taken;
  endproperty
  a_always: assert property (p_always) else $error("always code not taken");

  property p_add_z;
    @(posedge clk_sys) disable iff (rst)
    (opk == CSF_OP_ADD && !carry_in_use) |=> cpu_status_flags[`CSF_BIT_Z] == (8'($past(opa) + $past(opb)) == 8'h00);
  endproperty
  a_add_z: assert property (p_add_z) else $error("add zero wrong");

  property p_bittest_z;
    @(posedge clk_sys) disable iff (rst)
    opk == CSF_OP_BITTEST |=> cpu_status_flags[`CSF_BIT_Z] == ($past(result) == 8'h00) && cpu_status_flags[7] == $past(cpu_status_flags[7]);
  endproperty
  a_bittest_z: assert property (p_bittest_z) else $error("bit test zero wrong");

  property p_logic_s;
    @(posedge clk_sys) disable iff (rst)
    opk == CSF_OP_LOGIC |=> cpu_status_flags[`CSF_BIT_S] == $past(result[7]);
  endproperty
  a_logic_s: assert property (p_logic_s) else $error("logic sign wrong");

  property p_add_h;
    @(posedge clk_sys) disable iff (rst)
    (opk == CSF_OP_ADD && !carry_in_use) |=> cpu_status_flags[`CSF_BIT_H] == (({1'b0, $past(opa[3:0])} + {1'b0, $past(opb[3:0])}) > 5'h0f);
  endproperty
  a_add_h: assert property (p_add_h) else $error("add half carry wrong");

  property p_add_d;
    @(posedge clk_sys) disable iff (rst)
    opk == CSF_OP_ADD |=> !cpu_status_flags[`CSF_BIT_D];
  endproperty
  a_add_d: assert property (p_add_d) else $error("decimal bit after add wrong");

  property p_adj_c;
    @(posedge clk_sys) disable iff (rst)
    (opk == CSF_OP_DEC_ADJ && !cpu_status_flags[`CSF_BIT_D] && opa > 8'h99) |=> cpu_status_flags[`CSF_BIT_C];
  endproperty
  a_adj_c: assert property (p_adj_c) else $error("decimal adjust carry wrong");

  property p_ret;
    @(posedge clk_sys) disable iff (rst)
    opk == CSF_OP_INT_RETURN |=> !irq_block;
  endproperty
  a_ret: assert property (p_ret) else $error("return left fast irq bit");

  property p_fast_ret;
    @(posedge clk_sys) disable iff (rst)
    (opk == CSF_OP_INT_RETURN && irq_block) |-> fast_return;
  endproperty
  a_fast_ret: assert property (p_fast_ret) else $error("fast return missing");

  property p_bank0;
    @(posedge clk_sys) disable iff (rst)
    opk == CSF_OP_BANK0 |=> !bank_sel;
  endproperty
  a_bank0: assert property (p_bank0) else $error("bank zero wrong");

  property p_inv_c;
    @(posedge clk_sys) disable iff (rst)
    opk == CSF_OP_INV_C |=> cpu_status_flags[`CSF_BIT_C] != $past(cpu_status_flags[`CSF_BIT_C]);
  endproperty
  a_inv_c: assert property (p_inv_c) else $error("invert carry wrong");
endmodule : csf_status_flags
`default_nettype wire

/* File: sim/csf_dp_model.sv */
/*
  datapath model: result and shifted-out bit for the flag block.
  assumes op codes of csf_pkg; shift ops rotate left.
*/
`timescale 1ns/100ps
`default_nettype none
module csf_dp_model
  import csf_pkg::*;
(
  input wire logic [3:0] op,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  output logic [7:0] result,
  output logic shift_out
);
  // ==========
  // result path
  always_comb begin
    shift_out = opa[7];
    if (op == CSF_OP_SHIFT) begin
      result = {opa[6:0], opa[7]};
    end else begin
      result = opa & opb;
    end
  end
endmodule : csf_dp_model
`default_nettype wire

/* File: sim/tb.sv */
/*
  self-checking bench for csf_status_flags.
  assumes csf_pkg, csf_params.svh and csf_dp_model.
*/
`timescale 1ns/100ps
`default_nettype none
`include "csf_params.svh"
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin miscompares++; $display("mismatch %0t %s", $time, m); end end
module tb;
  import csf_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] op = '0;
  logic [7:0] opa = '0;
  logic [7:0] opb = '0;
  logic carry_in_use = 1'b0;
  logic [7:0] result;
  logic shift_out;
  logic [3:0] jump_condition_field = '0;
  logic jump_taken;
  logic irq_block;
  logic fast_return;
  logic bank_sel;
  logic [7:0] adj_result;
  logic [7:0] reg_rdata;
  logic [7:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] fl;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  // ==========
  // clock, parts, timeout
  always #10 clk_sys = ~clk_sys;
  csf_dp_model dp_u (.op(op), .opa(opa), .opb(opb), .result(result), .shift_out(shift_out));
  csf_status_flags dut_u (.clk_sys(clk_sys), .rst(rst), .op(op), .opa(opa), .opb(opb),
    .carry_in_use(carry_in_use), .result(result), .shift_out(shift_out),
    .jump_condition_field(jump_condition_field), .jump_taken(jump_taken), .adj_result(adj_result),
    .irq_block(irq_block), .fast_return(fast_return), .bank_sel(bank_sel), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic final_report;
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end
  // ==========
  // access tasks
  task automatic drive(input logic [3:0] o, input logic [7:0] a, input logic [7:0] b, input logic ci,
                       input logic w, input logic r, input logic [7:0] ad, input logic [7:0] wd);
    @(posedge clk_sys);
    op <= o;
    opa <= a;
    opb <= b;
    carry_in_use <= ci;
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= ad;
    reg_wdata <= wd;
  endtask : drive
  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    drive(CSF_OP_NONE, '0, '0, 1'b0, 1'b1, 1'b0, ad, wd);
  endtask : wr
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e);
    drive(CSF_OP_NONE, '0, '0, 1'b0, 1'b0, 1'b1, ad, '0);
    drive(CSF_OP_NONE, '0, '0, 1'b0, 1'b0, 1'b0, ad, '0);
    #1 `CHK(reg_rdata, e, "register read")
  endtask : rd_chk
  task automatic issue(input csf_op_e o, input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic c;
    c = ci & fl[7];
    case (o)
      CSF_OP_ADD: begin
        s = a + b + c;
        fl[7:2] = {s[8], s[7:0] == 8'h00, s[7], a[7] == b[7] && s[7] != a[7], 1'b0, a[3:0] + b[3:0] + c > 5'h0f};
      end
      CSF_OP_SUB: begin
        s = a - b - c;
        fl[7:2] = {s[8], s[7:0] == 8'h00, s[7], a[7] != b[7] && s[7] != a[7], 1'b1, {1'b0, a[3:0]} < b[3:0] + c};
      end
      CSF_OP_LOGIC: fl[6:4] = {(a & b) == 8'h00, a[7] & b[7], 1'b0};
      CSF_OP_SHIFT: fl[7:4] = {a[7], a == 8'h00, a[6], a[6] ^ a[7]};
      CSF_OP_BITTEST: fl[6] = (a & b) == 8'h00;
      CSF_OP_SET_C: fl[7] = 1'b1;
      CSF_OP_CLR_C: fl[7] = 1'b0;
      CSF_OP_INV_C: fl[7] = ~fl[7];
      CSF_OP_BANK0: fl[0] = 1'b0;
      CSF_OP_BANK1: fl[0] = 1'b1;
      CSF_OP_FAST_IRQ: fl[1] = 1'b1;
      CSF_OP_INT_RETURN: fl[1] = 1'b0;
      default: ;
    endcase
    drive(o, a, b, ci, 1'b0, 1'b0, 8'h00, '0);
  endtask : issue
  function automatic logic cond(input logic [3:0] code, input logic [3:0] f);
    logic t;
    case (code[2:0])
      3'h0: t = 1'b0;
      3'h1: t = f[1] ^ f[0];
      3'h2: t = f[2] | (f[1] ^ f[0]);
      3'h3: t = f[3] | f[2];
      3'h4: t = f[0];
      3'h5: t = f[1];
      3'h6: t = f[2];
      default: t = f[3];
    endcase
    return t ^ code[3];
  endfunction : cond
  // ==========
  // tests
  initial begin
    int i;
    int j;
    fl = 8'h00;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(`CSF_FLAGS_OFFSET, 8'h00);
    `CHK({irq_block, bank_sel}, 2'b00, "reset outputs")
    wr(8'hd4, 8'hff);
    rd_chk(8'hd4, 8'h00);
    rd_chk(`CSF_FLAGS_OFFSET, 8'h00);
    issue(CSF_OP_ADD, 8'h99, 8'h01, 1'b0);
    issue(CSF_OP_NONE, 8'h9a, 8'h00, 1'b0);
    #1 `CHK(adj_result, 8'h00, "adjust after add")
    issue(CSF_OP_DEC_ADJ, 8'h9a, 8'h00, 1'b0);
    fl[7:5] = 3'b110;
    rd_chk(`CSF_FLAGS_OFFSET, fl);
    issue(CSF_OP_ADD, 8'h7f, 8'h01, 1'b0);
    rd_chk(`CSF_FLAGS_OFFSET, fl);
    issue(CSF_OP_LOGIC, 8'hf0, 8'h0f, 1'b0);
    rd_chk(`CSF_FLAGS_OFFSET, fl);
    issue(CSF_OP_SUB, 8'h42, 8'h15, 1'b0);
    issue(CSF_OP_NONE, 8'h2d, 8'h00, 1'b0);
    #1 `CHK(adj_result, 8'h27, "adjust after sub")
    rd_chk(`CSF_FLAGS_OFFSET, fl);
    issue(CSF_OP_SUB, 8'h00, 8'h01, 1'b0);
    issue(CSF_OP_ADD, 8'hff, 8'h00, 1'b1);
    rd_chk(`CSF_FLAGS_OFFSET, fl);
    issue(CSF_OP_SHIFT, 8'h80, 8'h00, 1'b0);
    rd_chk(`CSF_FLAGS_OFFSET, fl);
    issue(CSF_OP_SHIFT, 8'h00, 8'h00, 1'b0);
    rd_chk(`CSF_FLAGS_OFFSET, fl);
    issue(CSF_OP_BITTEST, 8'h01, 8'h02, 1'b0);
    rd_chk(`CSF_FLAGS_OFFSET, fl);
    for (i = 6; i <= 8; i++) begin
      issue(csf_op_e'(i[3:0]), 8'h00, 8'h00, 1'b0);
      rd_chk(`CSF_FLAGS_OFFSET, fl);
    end
    issue(CSF_OP_BANK1, 8'h00, 8'h00, 1'b0);
    issue(CSF_OP_NONE, 8'h00, 8'h00, 1'b0);
    #1 `CHK(bank_sel, 1'b1, "bank one")
    issue(CSF_OP_BANK0, 8'h00, 8'h00, 1'b0);
    issue(CSF_OP_FAST_IRQ, 8'h00, 8'h00, 1'b0);
    #1 `CHK(bank_sel, 1'b0, "bank zero")
    issue(CSF_OP_INT_RETURN, 8'h00, 8'h00, 1'b0);
    #1 `CHK({irq_block, fast_return}, 2'b11, "fast return")
    issue(CSF_OP_NONE, 8'h00, 8'h00, 1'b0);
    #1 `CHK({irq_block, fast_return}, 2'b00, "return done")
    rd_chk(`CSF_FLAGS_OFFSET, fl);
    wr(`CSF_FLAGS_OFFSET, 8'ha5);
    rd_chk(`CSF_FLAGS_OFFSET, 8'ha5);
    for (i = 0; i < 16; i++) begin
      wr(`CSF_FLAGS_OFFSET, {i[3:0], i[0], 3'b000});
      issue(CSF_OP_NONE, 8'h00, 8'h00, 1'b0);
      for (j = 0; j < 16; j++) begin
        @(posedge clk_sys);
        jump_condition_field <= j[3:0];
        #1 `CHK(jump_taken, cond(j[3:0], i[3:0]), "jump condition")
      end
    end
    final_report();
  end
endmodule : tb
`default_nettype wire
